// File: rtl/drm_regs.svh
`ifndef DRM_REGS_SVH
`define DRM_REGS_SVH
// Mode-register addresses on the six-bit address field.
`define DRM_ADDR_BANK_MASK 6'h10
`define DRM_ADDR_SEG_MASK 6'h11
`define DRM_ADDR_OSC_LOW 6'h12
`define DRM_ADDR_OSC_HIGH 6'h13
`define DRM_ADDR_UPPER_INV 6'h14
// Reset values of the stored registers.
`define DRM_RST_BANK_MASK 8'h00
`define DRM_RST_SEG_MASK 8'h00
`define DRM_RST_UPPER_INV 8'h00
`define DRM_RST_OSC_COUNT 16'h0000
// Field positions: segment index sits in the top three row bits.
`define DRM_SEG_HI 16
`define DRM_SEG_LO 14
// Largest oscillator count; the counter holds there.
`define DRM_OSC_MAX 16'hFFFF
`endif

// File: rtl/drm_pkg.sv
`default_nettype none
package drm_pkg;
  // One register byte.
  typedef logic [7:0] drm_byte_t;
  // Oscillator count.
  typedef logic [15:0] drm_count_t;
  // Row address of a refresh request.
  typedef logic [16:0] drm_row_t;
  // Register selected by a mode-register address.
  typedef enum logic [2:0] {
    DRM_SEL_BANK,
    DRM_SEL_SEG,
    DRM_SEL_OSC_LOW,
    DRM_SEL_OSC_HIGH,
    DRM_SEL_INV,
    DRM_SEL_NONE
  } drm_sel_t;
endpackage
`default_nettype wire

// File: rtl/drm_mode_regs.sv
// Function
// RQ1: Bank mask bit one stops that bank's refresh.
// RQ2: Bank mask is held per channel.
// RQ3: Segment mask bit one stops segment refresh.
// RQ4: Segment is given by row bits sixteen..fourteen.
// RQ5: Segment mask is held per channel.
// RQ6: Low count register returns count bits 7..0.
// RQ7: High count register returns count bits 15..8.
// RQ8: Controller reads both bytes and joins them.
// RQ9: Start-oscillator command clears the stored count.
// RQ10: Controller may retune strobe phase from count.
// RQ11: Invert bit one inverts that upper calibration line.
// RQ12: Upper mask/inversion line is never inverted.
// RQ13: No bus inversion on calibration patterns.
// RQ14: Addresses 10h..14h select the five registers.
// RQ15: Invert bits 0..7 map to lines 8..15.
// RQ16: Read data on low lines, rest zero.
// RQ17: Writes to count registers are ignored.
`include "drm_regs.svh"
`default_nettype none

module drm_mode_regs (
  input  wire logic                clock,
  input  wire logic                nrst,
  input  wire logic                cmd_chan,
  input  wire logic                mrw_valid,
  input  wire logic                mrr_valid,
  input  wire logic [5:0]          mr_addr,
  input  wire drm_pkg::drm_byte_t  mr_wdata,
  input  wire logic [1:0]          osc_start,
  input  wire logic [1:0]          osc_stop,
  input  wire logic [1:0]          osc_tick,
  input  wire logic                ref_valid,
  input  wire logic                ref_chan,
  input  wire logic [2:0]          ref_bank,
  input  wire drm_pkg::drm_row_t   ref_row,
  input  wire logic                cal_valid,
  input  wire logic                cal_chan,
  input  wire drm_pkg::drm_byte_t  cal_pattern,
  input  wire logic                cal_dmi,
  output var  logic                rd_valid,
  output var  logic [15:0]         rd_data,
  output var  logic                ref_done,
  output var  logic                ref_grant,
  output var  logic                cal_out_valid,
  output var  drm_pkg::drm_byte_t  cal_dq_hi,
  output var  logic                cal_dmi_hi
);
  import drm_pkg::*;

  // Two-stage reset release; the rest of the block uses rst_n.
  logic       rst_meta_n;  // First stage, read only by the second.
  logic       rst_n;       // Synchronised reset, active low.

  // Stored per-channel registers.
  drm_byte_t  bank_mask [2];  // Bank refresh masks.
  drm_byte_t  seg_mask  [2];  // Segment refresh masks.
  drm_byte_t  upper_inv [2];  // Upper lane invert masks.
  drm_count_t osc_cnt   [2];  // Oscillator counts.
  logic       osc_run   [2];  // Oscillator running flags.

  // Next values of the register group.
  drm_byte_t  next_bank_mask [2];
  drm_byte_t  next_seg_mask  [2];
  drm_byte_t  next_upper_inv [2];

  // Next values of the output group.
  logic        next_rd_valid;
  logic [15:0] next_rd_data;
  logic        next_ref_done;
  logic        next_ref_grant;
  logic        next_cal_out_valid;
  drm_byte_t   next_cal_dq_hi;
  logic        next_cal_dmi_hi;

  // Maps a mode-register address onto the register it selects.
  function automatic drm_sel_t decode_addr(input logic [5:0] addr);
    case (addr)
      `DRM_ADDR_BANK_MASK: decode_addr = DRM_SEL_BANK;       // RQ14
      `DRM_ADDR_SEG_MASK:  decode_addr = DRM_SEL_SEG;        // RQ14
      `DRM_ADDR_OSC_LOW:   decode_addr = DRM_SEL_OSC_LOW;    // RQ14
      `DRM_ADDR_OSC_HIGH:  decode_addr = DRM_SEL_OSC_HIGH;   // RQ14
      `DRM_ADDR_UPPER_INV: decode_addr = DRM_SEL_INV;        // RQ14
      default:             decode_addr = DRM_SEL_NONE;
    endcase
  endfunction

  // Decoded register of the current command.
  drm_sel_t cmd_sel;
  assign cmd_sel = decode_addr(mr_addr);

  // Reset synchroniser: asserts at once, releases after two edges.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // Mode-register writes update only the addressed channel's copy.
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      next_bank_mask[c] = bank_mask[c];
      next_seg_mask[c]  = seg_mask[c];
      next_upper_inv[c] = upper_inv[c];
      // Only the channel named by the command is touched.
      if (mrw_valid && cmd_chan == c[0]) begin  // RQ2 RQ5
        case (cmd_sel)
          DRM_SEL_BANK: next_bank_mask[c] = mr_wdata;
          DRM_SEL_SEG:  next_seg_mask[c]  = mr_wdata;
          DRM_SEL_INV:  next_upper_inv[c] = mr_wdata;
          // Count registers are read-only; writes fall through here.
          default:      next_bank_mask[c] = bank_mask[c];  // RQ17
        endcase
      end
    end
  end

  // Registers the writable mode registers.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < 2; c++) begin
        bank_mask[c] <= `DRM_RST_BANK_MASK;
        seg_mask[c]  <= `DRM_RST_SEG_MASK;
        upper_inv[c] <= `DRM_RST_UPPER_INV;
      end
    end else begin
      bank_mask <= next_bank_mask;
      seg_mask  <= next_seg_mask;
      upper_inv <= next_upper_inv;
    end
  end

  // One oscillator counter per channel.
  for (genvar g = 0; g < 2; g++) begin : g_osc
    drm_count_t next_cnt;  // Next count.
    logic       next_run;  // Next running flag.

    // A start clears the count and runs; ticks add while running.
    always_comb begin
      next_cnt = osc_cnt[g];
      next_run = osc_run[g];
      if (osc_start[g]) begin
        // A fresh start wins over a tick in the same cycle.
        next_cnt = `DRM_RST_OSC_COUNT;  // RQ9
        next_run = 1'b1;
      end else begin
        // Count while running and hold at the top value.
        if (osc_run[g] && osc_tick[g] && osc_cnt[g] != `DRM_OSC_MAX) begin
          next_cnt = osc_cnt[g] + 16'h0001;
        end
        if (osc_stop[g]) begin
          next_run = 1'b0;
        end
      end
    end

    // Registers the count; writes never reach it.
    always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
        osc_cnt[g] <= `DRM_RST_OSC_COUNT;
        osc_run[g] <= 1'b0;
      end else begin
        osc_cnt[g] <= next_cnt;  // RQ17
        osc_run[g] <= next_run;
      end
    end
  end

  // Computes read data, refresh decision and calibration lines.
  always_comb begin
    next_rd_valid = mrr_valid;
    next_rd_data  = 16'h0000;
    // Read data sits on the low lines; upper lines stay zero.
    if (mrr_valid) begin  // RQ16
      case (cmd_sel)
        DRM_SEL_OSC_LOW:  next_rd_data[7:0] = osc_cnt[cmd_chan][7:0];   // RQ6
        DRM_SEL_OSC_HIGH: next_rd_data[7:0] = osc_cnt[cmd_chan][15:8];  // RQ7
        // Write-only and unmapped addresses read as zero.
        default:          next_rd_data = 16'h0000;
      endcase
    end
    // Refresh proceeds only if neither bank nor segment is masked.
    next_ref_done  = ref_valid;
    next_ref_grant = ref_valid
                     && !bank_mask[ref_chan][ref_bank]  // RQ1
                     && !seg_mask[ref_chan][ref_row[`DRM_SEG_HI:`DRM_SEG_LO]];  // RQ3 RQ4
    // Pattern goes out with per-line inversion and no bus inversion.
    next_cal_out_valid = cal_valid;
    next_cal_dq_hi     = cal_valid ? (cal_pattern ^ upper_inv[cal_chan]) : 8'h00;  // RQ11 RQ13 RQ15
    next_cal_dmi_hi    = cal_valid ? cal_dmi : 1'b0;  // RQ12
  end

  // Registers every output.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rd_valid      <= 1'b0;
      rd_data       <= 16'h0000;
      ref_done      <= 1'b0;
      ref_grant     <= 1'b0;
      cal_out_valid <= 1'b0;
      cal_dq_hi     <= 8'h00;
      cal_dmi_hi    <= 1'b0;
    end else begin
      rd_valid      <= next_rd_valid;
      rd_data       <= next_rd_data;
      ref_done      <= next_ref_done;
      ref_grant     <= next_ref_grant;
      cal_out_valid <= next_cal_out_valid;
      cal_dq_hi     <= next_cal_dq_hi;
      cal_dmi_hi    <= next_cal_dmi_hi;
    end
  end

  // A masked bank is never refreshed.
  property p_bank_mask;
    @(posedge clock) disable iff (!rst_n)
    ref_valid && bank_mask[ref_chan][ref_bank] |=> ref_done && !ref_grant;
  endproperty
  a_bank_mask: assert property (p_bank_mask) else $error("masked bank refreshed"); // RQ1

  // A write on channel zero leaves channel one's bank and segment masks alone.
  property p_chan_split;
    @(posedge clock) disable iff (!rst_n)
    mrw_valid && !cmd_chan |=> bank_mask[1] == $past(bank_mask[1]) && seg_mask[1] == $past(seg_mask[1]);
  endproperty
  a_chan_split: assert property (p_chan_split) else $error("other channel changed"); // RQ2

  // A row in a masked segment is never refreshed.
  property p_seg_mask;
    @(posedge clock) disable iff (!rst_n)
    ref_valid && seg_mask[ref_chan][ref_row[16:14]] |=> !ref_grant;
  endproperty
  a_seg_mask: assert property (p_seg_mask) else $error("masked segment refreshed"); // RQ4

  // Low count read returns the count's low byte.
  property p_read_low;
    @(posedge clock) disable iff (!rst_n)
    mrr_valid && mr_addr == `DRM_ADDR_OSC_LOW && !cmd_chan
      |=> rd_valid && rd_data == {8'h00, $past(osc_cnt[0][7:0])};
  endproperty
  a_read_low: assert property (p_read_low) else $error("low count read wrong"); // RQ6

  // High count read returns the count's high byte.
  property p_read_high;
    @(posedge clock) disable iff (!rst_n)
    mrr_valid && mr_addr == `DRM_ADDR_OSC_HIGH && cmd_chan
      |=> rd_valid && rd_data == {8'h00, $past(osc_cnt[1][15:8])};
  endproperty
  a_read_high: assert property (p_read_high) else $error("high count read wrong"); // RQ7

  // A start clears the count, which then stays clear without ticks.
  property p_start_clear;
    @(posedge clock) disable iff (!rst_n)
    osc_start[0] ##1 (!osc_tick[0] && !osc_start[0]) |-> osc_cnt[0] == 16'h0000 ##1 osc_cnt[0] == 16'h0000;
  endproperty
  a_start_clear: assert property (p_start_clear) else $error("start did not clear count"); // RQ9

  // Calibration lines carry the pattern xored with the invert mask.
  property p_cal_inv;
    @(posedge clock) disable iff (!rst_n)
    cal_valid && !cal_chan |=> cal_out_valid && cal_dq_hi == ($past(cal_pattern) ^ $past(upper_inv[0]));
  endproperty
  a_cal_inv: assert property (p_cal_inv) else $error("calibration inversion wrong"); // RQ11

  // The mask/inversion line carries the true pattern bit.
  property p_cal_dmi;
    @(posedge clock) disable iff (!rst_n)
    cal_valid |=> cal_dmi_hi == $past(cal_dmi);
  endproperty
  a_cal_dmi: assert property (p_cal_dmi) else $error("mask line altered"); // RQ12

  // Upper read lines are always zero.
  property p_rd_upper;
    @(posedge clock) disable iff (!rst_n)
    rd_valid |-> rd_data[15:8] == 8'h00;
  endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("upper read lines not zero"); // RQ16

  // A write to a count register leaves the idle count unchanged.
  property p_ro_write;
    @(posedge clock) disable iff (!rst_n)
    mrw_valid && !cmd_chan && mr_addr == `DRM_ADDR_OSC_HIGH && !osc_start[0] && !osc_tick[0]
      |=> osc_cnt[0] == $past(osc_cnt[0]);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("count changed by write"); // RQ17

  // A write on channel one leaves channel zero's segment and invert masks alone.
  property p_chan_split_one;
    @(posedge clock) disable iff (!rst_n)
    mrw_valid && cmd_chan |=> seg_mask[0] == $past(seg_mask[0]) && upper_inv[0] == $past(upper_inv[0]);
  endproperty
  a_chan_split_one: assert property (p_chan_split_one) else $error("channel zero changed"); // RQ5

  // An unmasked bank in an unmasked segment is refreshed.
  property p_ref_allowed;
    @(posedge clock) disable iff (!rst_n)
    ref_valid && !bank_mask[ref_chan][ref_bank] && !seg_mask[ref_chan][ref_row[16:14]]
      |=> ref_done && ref_grant;
  endproperty
  a_ref_allowed: assert property (p_ref_allowed) else $error("unmasked refresh refused"); // RQ3

  // Read lines rest at zero between answers.
  property p_rd_idle;
    @(posedge clock) disable iff (!rst_n)
    !rd_valid |-> rd_data == 16'h0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read lines not idle"); // RQ16

endmodule

`default_nettype wire

// File: dv/drm_ctrl_model.sv
`default_nettype none
// Controller model: issues mode-register commands and oscillator starts.
module drm_ctrl_model (
  input  wire logic               clock,
  input  wire logic               rd_valid,
  input  wire logic [15:0]        rd_data,
  output var  logic               cmd_chan,
  output var  logic               mrw_valid,
  output var  logic               mrr_valid,
  output var  logic [5:0]         mr_addr,
  output var  drm_pkg::drm_byte_t mr_wdata,
  output var  logic [1:0]         osc_start
);
  timeunit 1ns;
  timeprecision 100ps;
  import drm_pkg::*;
  initial begin
    {cmd_chan, mrw_valid, mrr_valid, mr_addr, mr_wdata, osc_start} = '0;
  end
  // One write pulse; released address and data show the inverse, cmd_chan keeps its value.
  task automatic mode_reg_write(input logic ch, input logic [5:0] a, input drm_byte_t d);
    @(posedge clock);
    {cmd_chan, mr_addr, mr_wdata, mrw_valid} <= {ch, a, d, 1'b1};
    @(posedge clock);
    {mr_addr, mr_wdata, mrw_valid} <= {~a, ~d, 1'b0};
  endtask
  // One read pulse; the answer is taken one edge later.
  task automatic mode_reg_read(input logic ch, input logic [5:0] a, output logic ok, output logic [15:0] q);
    @(posedge clock);
    {cmd_chan, mr_addr, mrr_valid} <= {ch, a, 1'b1};
    @(posedge clock);
    {mr_addr, mrr_valid} <= {~a, 1'b0};
    #1;
    ok = rd_valid;
    q = rd_data;
  endtask
  // Both count bytes are read and joined, high byte on top.
  task automatic read_count(input logic ch, output logic ok, output logic [15:0] c);
    logic        k0;
    logic        k1;
    logic [15:0] lo;
    logic [15:0] hi;
    mode_reg_read(ch, 6'h12, k0, lo);
    mode_reg_read(ch, 6'h13, k1, hi);
    ok = k0 & k1 & (lo[15:8] === 8'h00) & (hi[15:8] === 8'h00);
    c = {hi[7:0], lo[7:0]};
  endtask
  // Fresh start command clears the channel's count.
  task automatic osc_go(input logic ch);
    @(posedge clock);
    osc_start[ch] <= 1'b1;
    @(posedge clock);
    osc_start <= 2'b00;
  endtask
endmodule
`default_nettype wire

// File: dv/dram_refresh_mask_osc_invert_regs_bench.sv
`default_nettype none
// Random and corner stimulus against a reference of masks and counts.
module dram_refresh_mask_osc_invert_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import drm_pkg::*;
  logic clock, nrst, cmd_chan, mrw_valid, mrr_valid, ref_valid, ref_chan, cal_valid, cal_chan, cal_dmi;
  logic rd_valid, ref_done, ref_grant, cal_out_valid, cal_dmi_hi, ok;
  logic [5:0] mr_addr;
  logic [1:0] osc_start, osc_stop, osc_tick;
  logic [2:0] ref_bank;
  logic [15:0] rd_data, q;
  drm_byte_t mr_wdata, cal_pattern, cal_dq_hi;
  drm_row_t ref_row;
  drm_byte_t bm [2], sm [2], iv [2];
  int errors, comparisons, n;
  drm_mode_regs drm_mode_regs_i (.clock(clock), .nrst(nrst), .cmd_chan(cmd_chan), .mrw_valid(mrw_valid),
    .mrr_valid(mrr_valid), .mr_addr(mr_addr), .mr_wdata(mr_wdata), .osc_start(osc_start), .osc_stop(osc_stop),
    .osc_tick(osc_tick), .ref_valid(ref_valid), .ref_chan(ref_chan), .ref_bank(ref_bank), .ref_row(ref_row),
    .cal_valid(cal_valid), .cal_chan(cal_chan), .cal_pattern(cal_pattern), .cal_dmi(cal_dmi),
    .rd_valid(rd_valid), .rd_data(rd_data), .ref_done(ref_done), .ref_grant(ref_grant),
    .cal_out_valid(cal_out_valid), .cal_dq_hi(cal_dq_hi), .cal_dmi_hi(cal_dmi_hi));
  drm_ctrl_model drm_ctrl_model_i (.clock(clock), .rd_valid(rd_valid), .rd_data(rd_data), .cmd_chan(cmd_chan),
    .mrw_valid(mrw_valid), .mrr_valid(mrr_valid), .mr_addr(mr_addr), .mr_wdata(mr_wdata), .osc_start(osc_start));
  always #5 clock = ~clock;
  // Counts a comparison and reports a failed one.
  task automatic chk(input logic good, input string msg);
    comparisons++;
    if (good !== 1'b1) begin
      errors++;
      $display("MISMATCH t=%0t %s", $time, msg);
    end
  endtask
  // Prints the counts and the verdict, then stops.
  task automatic final_report;
    $display("errors=%0d comparisons=%0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Refresh is allowed only when neither bank nor row segment is masked.
  function automatic logic exp_grant(input logic ch, input logic [2:0] b, input drm_row_t r);
    return !bm[ch][b] && !sm[ch][r[16:14]];
  endfunction
  // Writes a register and mirrors it; count addresses leave the mirror alone.
  task automatic wr(input logic ch, input logic [5:0] a, input drm_byte_t d);
    drm_ctrl_model_i.mode_reg_write(ch, a, d);
    if (a == 6'h10) bm[ch] = d;
    if (a == 6'h11) sm[ch] = d;
    if (a == 6'h14) iv[ch] = d;
  endtask
  task automatic refq(input logic ch, input logic [2:0] b, input drm_row_t r);
    @(posedge clock);
    {ref_valid, ref_chan, ref_bank, ref_row} <= {1'b1, ch, b, r};
    @(posedge clock);
    ref_valid <= 1'b0;
    #1 chk(ref_done === 1'b1 && ref_grant === exp_grant(ch, b, r), "refresh grant");
  endtask
  task automatic calq(input logic ch, input drm_byte_t p, input logic m);
    @(posedge clock);
    {cal_valid, cal_chan, cal_pattern, cal_dmi} <= {1'b1, ch, p, m};
    @(posedge clock);
    cal_valid <= 1'b0;
    #1 chk(cal_out_valid === 1'b1 && cal_dq_hi === (p ^ iv[ch]) && cal_dmi_hi === m, "calibration");
  endtask
  // Watchdog: a hang counts as a mismatch.
  initial begin
    repeat (50000) @(posedge clock);
    errors++;
    final_report;
  end
  initial begin
    {clock, nrst, osc_tick, osc_stop, ref_valid, ref_chan, ref_bank, ref_row} = '0;
    {cal_valid, cal_chan, cal_pattern, cal_dmi} = '0;
    bm = '{8'h00, 8'h00};
    sm = bm;
    iv = bm;
    void'($urandom(32'h7c78));
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    repeat (3) @(posedge clock);
    // Every mapped address and both neighbours read zero after reset.
    for (int a = 15; a <= 21; a++) begin
      drm_ctrl_model_i.mode_reg_read(a[0], a[5:0], ok, q);
      chk(ok === 1'b1 && q === 16'h0000, "reset read");
    end
    $display("test reset done");
    // Segment boundary corner, then random writes, queries and patterns.
    wr(1'b1, 6'h11, 8'h80);
    refq(1'b1, 3'd0, 17'h1_C000);
    refq(1'b1, 3'd0, 17'h1_BFFF);
    for (int i = 0; i < 60; i++) begin
      wr(1'($urandom), 6'h10 + 6'($urandom_range(4)), 8'($urandom));
      refq(1'($urandom), 3'($urandom), 17'($urandom));
      calq(1'($urandom), 8'($urandom), 1'($urandom));
      drm_ctrl_model_i.mode_reg_read(1'($urandom), 6'h10 + 6'($urandom_range(4)), ok, q);
      chk(ok === 1'b1 && q === 16'h0000, "write-only or count read");
    end
    $display("test masks done");
    // Both channels tick across the byte boundary; only channel 0 is stopped.
    // Three late ticks then reach channel 1 but not the stopped channel 0.
    drm_ctrl_model_i.osc_go(1'b0);
    drm_ctrl_model_i.osc_go(1'b1);
    n = 260 + $urandom_range(300);
    @(posedge clock);
    osc_tick <= 2'b11;
    repeat (n) @(posedge clock);
    {osc_tick, osc_stop} <= {2'b00, 2'b01};
    @(posedge clock);
    {osc_tick, osc_stop} <= {2'b11, 2'b00};
    repeat (3) @(posedge clock);
    osc_tick <= 2'b00;
    drm_ctrl_model_i.read_count(1'b0, ok, q);
    chk(ok === 1'b1 && q === 16'(n), "count channel 0");
    drm_ctrl_model_i.read_count(1'b1, ok, q);
    chk(ok === 1'b1 && q === 16'(n + 3), "count channel 1");
    wr(1'b0, 6'h12, 8'hFF);
    wr(1'b0, 6'h13, 8'hFF);
    drm_ctrl_model_i.read_count(1'b0, ok, q);
    chk(ok === 1'b1 && q === 16'(n), "count after write");
    drm_ctrl_model_i.osc_go(1'b0);
    drm_ctrl_model_i.read_count(1'b0, ok, q);
    chk(ok === 1'b1 && q === 16'h0000, "count after restart");
    $display("test oscillator done");
    final_report;
  end
endmodule
`default_nettype wire
